// ### src/second_clock_output_cfg_pkg.sv
// Package: offsets, field positions, reset values and driver mode encodings
package second_out_cfg_pkg;
  localparam logic [7:0] SRC_SEL_ADDR = 8'h33;
  localparam logic [7:0] DRV_CTL_ADDR = 8'h34;
  localparam logic [7:0] SRC_SEL_RESET = 8'h00;
  localparam logic [7:0] DRV_CTL_RESET = 8'ha8;
  localparam int SRC_BIT = 3;
  localparam int STRENGTH_BIT = 7;
  localparam int PWRDN_BIT = 6;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 3;
  localparam int POL_HI = 2;
  localparam int POL_LO = 1;
  localparam int REGCTL_BIT = 0;
  localparam logic [2:0] MODE_CMOS_BOTH = 3'h0;
  localparam logic [2:0] MODE_CMOS_POS = 3'h1;
  localparam logic [2:0] MODE_CMOS_NEG = 3'h2;
  localparam logic [2:0] MODE_CMOS_NONE = 3'h3;
  localparam logic [2:0] MODE_LVDS = 3'h4;
  localparam logic [2:0] MODE_LVPECL = 3'h5;

  // Driver mode presented to the analog output stage
  typedef enum logic [4:0] {
    DRV_CMOS = 5'b00001,
    DRV_LVDS = 5'b00010,
    DRV_LVPECL = 5'b00100,
    DRV_TRISTATE = 5'b01000,
    DRV_UNUSED = 5'b10000
  } drv_kind_e;

  // Decoded settings for the second clock output driver
  typedef struct packed {
    logic use_reference;
    logic strong_drive;
    logic power_down;
    drv_kind_e kind;
    logic pos_enable;
    logic neg_enable;
    logic pos_invert;
    logic neg_invert;
  } drv_cfg_s;
endpackage

// ### src/second_clock_output_cfg_reg.sv
// Single 8-bit configuration register with write strobe and reset value
`timescale 1ns/1ps
`default_nettype none
module second_out_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] USED_MASK = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0] value_q
);
  // Unused bits stay at their reset value, so they cannot steer anything
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value_q <= RESET_VALUE;
    else if (wr_en)
      value_q <= (wr_data & USED_MASK) | (RESET_VALUE & ~USED_MASK);
  end
endmodule // second_out_cfg_reg
`default_nettype wire

// ### src/second_output_config_regs.sv
// Second clock output source and driver configuration registers
`timescale 1ns/1ps
`default_nettype none
module second_output_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial port engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Output format select pin, high picks LVPECL while driver register bit 0 is clear (pin control)
  input wire logic output_format_select_pin,
  // Decoded settings to the second clock output stage
  output var second_out_cfg_pkg::drv_cfg_s second_clock_output_cfg
);
  import second_out_cfg_pkg::*;

  // Only the source bit is stored; the other bits read back as zero
  localparam logic [7:0] SRC_USED_MASK = 8'(8'h01 << SRC_BIT);
  // Every driver bit has a meaning, so all of them are stored
  localparam logic [7:0] DRV_USED_MASK = 8'hff;
  // Pin control out of reset; pin not yet sampled, so LVDS is assumed
  localparam drv_cfg_s CFG_RESET = '{
    use_reference: 1'b0,
    strong_drive: 1'b1,
    power_down: 1'b0,
    kind: DRV_LVDS,
    pos_enable: 1'b1,
    neg_enable: 1'b1,
    pos_invert: 1'b0,
    neg_invert: 1'b0
  };

  // Stored register images
  logic [7:0] src_q;
  logic [7:0] drv_q;
  // Write strobes, one per register
  logic src_wr;
  logic drv_wr;
  // Fields of the driver register
  logic strength_f;
  logic pwrdn_f;
  logic [2:0] mode_f;
  logic [1:0] pol_f;
  logic reg_control;
  // Next values of the registered outputs
  logic [7:0] rdata_d;
  drv_cfg_s cfg_d;

  // Address match, shared by the write strobes and the read mux
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return addr == target;
  endfunction

  // CMOS encodings; the polarity field means nothing outside them
  function automatic logic is_cmos(input logic [2:0] mode);
    logic hit;
    case (mode)
      MODE_CMOS_BOTH,
      MODE_CMOS_POS,
      MODE_CMOS_NEG,
      MODE_CMOS_NONE:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Driver kind for a register-controlled mode code
  function automatic drv_kind_e mode_kind(input logic [2:0] mode);
    drv_kind_e kind;
    case (mode)
      MODE_CMOS_BOTH,
      MODE_CMOS_POS,
      MODE_CMOS_NEG:
        kind = DRV_CMOS;
      MODE_CMOS_NONE:
        kind = DRV_TRISTATE;
      MODE_LVDS:
        kind = DRV_LVDS;
      MODE_LVPECL:
        kind = DRV_LVPECL;
      default:
        kind = DRV_UNUSED;
    endcase
    return kind;
  endfunction

  // Positive pin drives in both-pin CMOS, positive-only CMOS and differential
  function automatic logic pos_active(input logic [2:0] mode);
    logic on;
    case (mode)
      MODE_CMOS_BOTH,
      MODE_CMOS_POS,
      MODE_LVDS,
      MODE_LVPECL:
        on = 1'b1;
      default:
        on = 1'b0;
    endcase
    return on;
  endfunction

  // Negative pin drives in both-pin CMOS, negative-only CMOS and differential
  function automatic logic neg_active(input logic [2:0] mode);
    logic on;
    case (mode)
      MODE_CMOS_BOTH,
      MODE_CMOS_NEG,
      MODE_LVDS,
      MODE_LVPECL:
        on = 1'b1;
      default:
        on = 1'b0;
    endcase
    return on;
  endfunction

  // Only bit 3 of the source register is implemented
  second_out_cfg_reg #(
    .RESET_VALUE(SRC_SEL_RESET),
    .USED_MASK(SRC_USED_MASK)
  ) u_src (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(src_wr),
    .wr_data(reg_wdata),
    .value_q(src_q)
  );

  second_out_cfg_reg #(
    .RESET_VALUE(DRV_CTL_RESET),
    .USED_MASK(DRV_USED_MASK)
  ) u_drv (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(drv_wr),
    .wr_data(reg_wdata),
    .value_q(drv_q)
  );

  // Writes to any other address are dropped silently
  assign src_wr = reg_wr && addr_hit(reg_addr, SRC_SEL_ADDR);
  assign drv_wr = reg_wr && addr_hit(reg_addr, DRV_CTL_ADDR);

  // Driver register fields
  assign strength_f = drv_q[STRENGTH_BIT];
  assign pwrdn_f = drv_q[PWRDN_BIT];
  assign mode_f = drv_q[MODE_HI:MODE_LO];
  assign pol_f = drv_q[POL_HI:POL_LO];
  assign reg_control = drv_q[REGCTL_BIT];

  // Unmapped addresses read zero, so a stray read never aliases a register
  always_comb
  begin
    rdata_d = 8'h00;
    if (addr_hit(reg_addr, SRC_SEL_ADDR))
      rdata_d = src_q;
    else if (addr_hit(reg_addr, DRV_CTL_ADDR))
      rdata_d = drv_q;
  end

  // Read data registered: one cycle after the address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_d;
  end

  always_comb
  begin
    cfg_d = '0;
    cfg_d.use_reference = src_q[SRC_BIT];
    if (!reg_control)
    begin
      // Pin control: bits [7:1] ignored entirely
      cfg_d.strong_drive = 1'b1;
      cfg_d.power_down = 1'b0;
      cfg_d.kind = output_format_select_pin ? DRV_LVPECL : DRV_LVDS;
      cfg_d.pos_enable = 1'b1;
      cfg_d.neg_enable = 1'b1;
    end
    else
    begin
      cfg_d.strong_drive = strength_f;
      cfg_d.power_down = pwrdn_f;
      cfg_d.kind = mode_kind(mode_f);
      cfg_d.pos_enable = pos_active(mode_f);
      cfg_d.neg_enable = neg_active(mode_f);
      if (is_cmos(mode_f))
      begin
        // Inversion relative to default: pos true-high, neg true-low
        cfg_d.pos_invert = pol_f[1];
        cfg_d.neg_invert = pol_f[0];
      end
    end
  end

  // Registered so the analog stage never sees decode glitches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      second_clock_output_cfg <= CFG_RESET;
    else
      second_clock_output_cfg <= cfg_d;
  end
endmodule // second_output_config_regs
`default_nettype wire

// ### sim/reg_host.sv
// Host model for the register port
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial {reg_addr, reg_wr, reg_wdata} = '0;
  // Data inverted once released so stale values never look valid
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    v = reg_rdata;
  endtask
endmodule // reg_host
`default_nettype wire

// ### sim/second_output_config_regs_monitor.sv
// Checker for second output config registers
`timescale 1ns/1ps
`default_nettype none
module second_output_config_regs_monitor
  import second_out_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port and decoded settings
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire second_out_cfg_pkg::drv_cfg_s second_clock_output_cfg
);
  wire drv_cfg_s c = second_clock_output_cfg;
  wire logic w4 = reg_wr && reg_addr == 8'h34;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  src_route_a: assert property (reg_wr && reg_addr == 8'h33 |=> ##1
    c.use_reference == $past(reg_wdata[3], 2)) else $error("source");
  drive_strength_a: assert property (w4 && reg_wdata[0] |=> ##1
    c.strong_drive == $past(reg_wdata[7], 2)) else $error("strength");
  power_down_a: assert property (w4 && reg_wdata[0] |=> ##1
    c.power_down == $past(reg_wdata[6], 2)) else $error("power");
  mode_lvds_a: assert property (w4 && reg_wdata[5:0] == 6'h21 |=> ##1
    c.kind == DRV_LVDS) else $error("mode");
  pol_ignored_a: assert property (w4 && reg_wdata[5] && reg_wdata[0] |=> ##1
    !c.pos_invert && !c.neg_invert) else $error("polarity");
  pol_map_a: assert property (w4 && reg_wdata[0] && !reg_wdata[5] |=> ##1
    c.pos_invert == $past(reg_wdata[2], 2) && c.neg_invert == $past(reg_wdata[1], 2))
    else $error("polarity map");
  pin_control_a: assert property (w4 && !reg_wdata[0] |=> ##1
    c.strong_drive && !c.power_down && c.pos_enable) else $error("pin");
  unmapped_rd_a: assert property (!(reg_addr inside {8'h33, 8'h34}) |=>
    reg_rdata == 8'h00) else $error("unmapped");
  src_unused_a: assert property (reg_addr == 8'h33 |=>
    (reg_rdata & 8'hf7) == 8'h00) else $error("unused");
endmodule // second_output_config_regs_monitor
bind second_output_config_regs second_output_config_regs_monitor mon (.clk, .rst_n,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .second_clock_output_cfg);
`default_nettype wire

// ### sim/test_second_output_config_regs.sv
// Self-checking bench for second output config registers
`timescale 1ns/1ps
`default_nettype none
module test_second_output_config_regs;
  import second_out_cfg_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic pin = 0;
  wire logic [7:0] a, wd, rdat;
  wire logic w;
  wire drv_cfg_s cfg;
  logic [7:0] src = 8'h00, drv = 8'ha8, v, x;
  integer seed = 8;
  int num_errors = 0, n_tests = 0;
  initial forever #4 clk = ~clk;
  reg_host h (.clk, .reg_addr(a), .reg_wr(w), .reg_wdata(wd), .reg_rdata(rdat));
  second_output_config_regs dut (.clk, .rst_n, .reg_addr(a), .reg_wr(w), .reg_wdata(wd),
    .reg_rdata(rdat), .output_format_select_pin(pin), .second_clock_output_cfg(cfg));
  task automatic chk(string n, logic [11:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic drv_cfg_s ex();
    logic [2:0] m;
    drv_cfg_s e;
    m = drv[5:3];
    e = {src[3], 2'b10, pin ? DRV_LVPECL : DRV_LVDS, 4'b1100};
    if (drv[0])
    begin
      e.strong_drive = drv[7];
      e.power_down = drv[6];
      e.kind = m[2] ? (m[1] ? DRV_UNUSED : m[0] ? DRV_LVPECL : DRV_LVDS) :
        m == 3 ? DRV_TRISTATE : DRV_CMOS;
      e.pos_enable = m == 0 || m == 1 || m[2:1] == 2;
      e.neg_enable = m == 0 || m == 2 || m[2:1] == 2;
      e.pos_invert = !m[2] && drv[2];
      e.neg_invert = !m[2] && drv[1];
    end
    return e;
  endfunction
  task automatic look(logic [7:0] ad);
    logic [7:0] r;
    h.rd(ad, r);
    chk("rdata", 12'(r), 12'(ad == 8'h33 ? src : ad == 8'h34 ? drv : 8'h00));
    chk("cfg", cfg, ex());
  endtask
  task automatic results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    look(8'h33);
    look(8'h34);
    // First 32 passes sweep every mode and polarity under register control
    for (int i = 0; i < 96; i++)
    begin
      x = 8'($random(seed));
      if (i < 32) x[5:0] = {i[4:0], 1'b1};
      v = (i < 32 || i[0]) ? 8'h34 : i[1] ? 8'h33 : 8'($random(seed));
      @(posedge clk);
      pin <= 1'($random(seed));
      h.wr(v, x);
      if (v == 8'h33) src = x & 8'h08;
      if (v == 8'h34) drv = x;
      look(v);
    end
    results;
  end
endmodule // test_second_output_config_regs
`default_nettype wire
